// [src/cng_pkg.sv]
// package: constants and types of the can node state and guarding block
package cng_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_CYCLES = 16;
  // frame identifiers and lengths
  localparam logic [10:0] ID_NMT = 11'h000;
  localparam logic [10:0] ID_GUARD_BASE = 11'h700;
  localparam logic [3:0] DLC_NMT = 4'h2;
  localparam logic [3:0] DLC_REQ = 4'h0;
  localparam logic [3:0] DLC_REPLY = 4'h1;
  localparam logic [7:0] BOOT_DATA = 8'h00;
  // command codes and destinations
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_PREOP = 8'h80;
  localparam logic [7:0] CMD_RST_NODE = 8'h81;
  localparam logic [7:0] CMD_RST_COMM = 8'h82;
  localparam logic [7:0] DEST_ALL = 8'h00;
  // state codes in the guard reply
  localparam logic [6:0] CODE_INIT = 7'h00;
  localparam logic [6:0] CODE_STOP = 7'h04;
  localparam logic [6:0] CODE_OPER = 7'h05;
  localparam logic [6:0] CODE_PREOP = 7'h7f;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_GUARD_INTERVAL = 16'h100c;
  localparam logic [15:0] IDX_LIFE_FACTOR = 16'h100d;
  localparam logic [15:0] IDX_CTRL = 16'h1010;
  localparam logic [15:0] IDX_STATUS = 16'h1011;
  localparam logic [31:0] ADDR_GUARD_INTERVAL = {14'h0000, IDX_GUARD_INTERVAL, 2'b00};
  localparam logic [31:0] ADDR_LIFE_FACTOR = {14'h0000, IDX_LIFE_FACTOR, 2'b00};
  localparam logic [31:0] ADDR_CTRL = {14'h0000, IDX_CTRL, 2'b00};
  localparam logic [31:0] ADDR_STATUS = {14'h0000, IDX_STATUS, 2'b00};
  // field positions
  localparam int unsigned CTRL_NODE_LSB = 0;
  localparam int unsigned CTRL_HB_BIT = 8;
  localparam int unsigned STAT_CODE_LSB = 0;
  localparam int unsigned STAT_ALARM_BIT = 8;
  localparam int unsigned STAT_TOGGLE_BIT = 9;
  localparam int unsigned STAT_ACTIVE_BIT = 10;
  localparam int unsigned STAT_ENABLE_BIT = 11;
  // reset values
  localparam logic [15:0] GUARD_INTERVAL_RST = 16'h0000;
  localparam logic [7:0] LIFE_FACTOR_RST = 8'h00;
  localparam logic [6:0] NODE_ID_RST = 7'h00;

  typedef enum logic [4:0] {
    CNG_INIT = 5'b0_0001,
    CNG_BOOT = 5'b0_0010,
    CNG_PREOP = 5'b0_0100,
    CNG_OPER = 5'b0_1000,
    CNG_STOP = 5'b1_0000
  } cng_state_t;

  typedef struct packed {
    logic valid;
    logic rtr;
    logic [10:0] id;
    logic [3:0] dlc;
    logic [7:0] d0;
    logic [7:0] d1;
  } cng_rx_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [7:0] d0;
  } cng_tx_t;

  typedef struct packed {
    logic pdo;
    logic sdo;
    logic sync;
    logic emcy;
    logic nmt;
  } cng_permit_t;
endpackage : cng_pkg

// [src/cng_ms_tick.sv]
// one-millisecond tick divider
`timescale 1ns/1ps
module cng_ms_tick #(
  parameter int unsigned TICK_CYCLES = cng_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // tick out
  output logic tick
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } cng_tick_st_t;

  cng_tick_st_t st_reg;
  cng_tick_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == LAST) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1; // [RULE_23]
    end else begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : cng_ms_tick

// [src/cng_guard_timer.sv]
// guard supervision timer: interval counter and missed-interval counter
`timescale 1ns/1ps
module cng_guard_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic restart,
  input wire logic tick,
  input wire logic [15:0] interval_ms,
  input wire logic [7:0] life,
  // status
  output logic active,
  output logic timeout
);
  typedef struct packed {
    logic active;
    logic [15:0] ms;
    logic [7:0] miss;
    logic timeout;
  } cng_gt_st_t;

  cng_gt_st_t st_reg;
  cng_gt_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.timeout = 1'b0;
    if (!enable) begin
      st_next.active = 1'b0; // [RULE_11]
    end else if (restart) begin
      st_next.active = 1'b1; // [RULE_12]
      st_next.ms = 16'h0000; // [RULE_23]
      st_next.miss = 8'h00;
    end else if (st_reg.active && tick) begin
      if (st_reg.ms + 16'h0001 >= interval_ms) begin
        st_next.ms = 16'h0000;
        st_next.miss = st_reg.miss + 8'h01;
        // total time is interval times life factor
        if (st_reg.miss + 8'h01 >= life) begin
          st_next.timeout = 1'b1; // [RULE_10]
          st_next.active = 1'b0;
        end
      end else begin
        st_next.ms = st_reg.ms + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign active = st_reg.active;
  assign timeout = st_reg.timeout;
endmodule : cng_guard_timer

// [src/cng_node.sv]
// can node state machine, command decode, message gating and node guarding
//
// Overview of operation
// [RULE_01] power-on enters init, then preoperational automatically
// [RULE_02] leaving init sends boot-up 700h+node, byte zero
// [RULE_03] init ignores bus traffic except final boot-up
// [RULE_04] command frame: id 00h, code, destination
// [RULE_05] codes 1,2,128,129,130 select state or reset
// [RULE_06] act only for destination 0 or own node
// [RULE_07] commands are never answered
// [RULE_08] node reset restarts all; comm reset reinitializes link
// [RULE_09] per-state gating of process, service, sync, emergency, management
// [RULE_10] supervision time is interval times life factor
// [RULE_11] zero interval or life factor disables supervision
// [RULE_12] timing starts at first guard request
// [RULE_13] master requests are remote frames 700h+node
// [RULE_14] master sends guard requests periodically
// [RULE_15] answer each guard request with 700h+node
// [RULE_16] reply bits 6:0 carry 4, 5 or 127
// [RULE_17] reply bit 7 toggles every reply
// [RULE_18] timeout forces preoperational and raises loss alarm
// [RULE_19] guarding stays active in stopped state
// [RULE_20] re-enabling supervision clears the loss alarm
// [RULE_21] guard interval down to 1 ms accepted
// [RULE_22] heartbeat and guarding never both enabled
// [RULE_23] millisecond tick drives interval, restarted per request
`timescale 1ns/1ps
module cng_node #(
  parameter int unsigned TICK_CYCLES = cng_pkg::MS_CYCLES,
  parameter int unsigned INIT_CYCLES = cng_pkg::INIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // frames from the can controller
  input wire cng_pkg::cng_rx_t rx,
  // frames to the can controller
  output logic tx_valid,
  input wire logic tx_ready,
  output cng_pkg::cng_tx_t tx,
  // message gating and indications
  output cng_pkg::cng_permit_t permit,
  output logic guard_loss_alarm,
  output logic device_reset_req,
  output logic comm_reset_pulse
);
  localparam logic [7:0] INIT_LOAD = 8'(INIT_CYCLES - 1);

  typedef struct packed {
    cng_pkg::cng_state_t state;
    logic [7:0] init_cnt;
    logic [15:0] guard_interval;
    logic [7:0] life_factor;
    logic [6:0] node_id;
    logic hb_en;
    logic wr_pend;
    logic [31:0] addr;
    logic [31:0] rdata;
    logic tx_valid;
    logic tx_is_reply;
    cng_pkg::cng_tx_t tx;
    logic reply_pend;
    logic toggle;
    logic alarm;
    logic sup_en_d;
    cng_pkg::cng_permit_t permit;
    logic dev_rst;
    logic comm_rst;
  } cng_node_st_t;

  cng_node_st_t st_reg;
  cng_node_st_t st_next;

  logic tick;
  logic sup_en;
  logic sup_active;
  logic sup_timeout;
  logic online;
  logic own_node;
  logic guard_req;
  logic nmt_cmd;
  logic [10:0] own_id;
  logic [6:0] code;

  cng_ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  cng_guard_timer u_guard (
    .clk(clk),
    .rst_n(rst_n),
    .enable(sup_en),
    .restart(guard_req),
    .tick(tick),
    .interval_ms(st_reg.guard_interval),
    .life(st_reg.life_factor),
    .active(sup_active),
    .timeout(sup_timeout)
  );

  // frame decode; init and boot states see no traffic
  always_comb begin
    online = (st_reg.state == cng_pkg::CNG_PREOP) || (st_reg.state == cng_pkg::CNG_OPER) ||
             (st_reg.state == cng_pkg::CNG_STOP); // [RULE_03]
    own_node = (st_reg.node_id != 7'h00);
    own_id = cng_pkg::ID_GUARD_BASE + {4'h0, st_reg.node_id};
    guard_req = online && own_node && rx.valid && rx.rtr && (rx.id == own_id) &&
                (rx.dlc == cng_pkg::DLC_REQ); // [RULE_13] [RULE_19]
    nmt_cmd = online && rx.valid && !rx.rtr && (rx.id == cng_pkg::ID_NMT) &&
              (rx.dlc == cng_pkg::DLC_NMT) && // [RULE_04]
              ((rx.d1 == cng_pkg::DEST_ALL) || (own_node && (rx.d1 == {1'b0, st_reg.node_id}))); // [RULE_06]
    // heartbeat enabled means guarding is held off; a 1 ms interval is legal
    sup_en = (st_reg.guard_interval != 16'h0000) && (st_reg.life_factor != 8'h00) &&
             !st_reg.hb_en && online; // [RULE_11] [RULE_21] [RULE_22]
    case (st_reg.state)
      cng_pkg::CNG_STOP: code = cng_pkg::CODE_STOP; // [RULE_16]
      cng_pkg::CNG_OPER: code = cng_pkg::CODE_OPER;
      cng_pkg::CNG_PREOP: code = cng_pkg::CODE_PREOP;
      default: code = cng_pkg::CODE_INIT;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.dev_rst = 1'b0;
    st_next.comm_rst = 1'b0;
    st_next.sup_en_d = sup_en;

    // bus data phase: whole-word writes, status is read-only
    if (st_reg.wr_pend) begin
      case (st_reg.addr)
        cng_pkg::ADDR_GUARD_INTERVAL: st_next.guard_interval = hwdata[15:0];
        cng_pkg::ADDR_LIFE_FACTOR: st_next.life_factor = hwdata[7:0];
        cng_pkg::ADDR_CTRL: begin
          st_next.node_id = hwdata[cng_pkg::CTRL_NODE_LSB +: 7];
          st_next.hb_en = hwdata[cng_pkg::CTRL_HB_BIT];
        end
        default: ;
      endcase
    end
    st_next.wr_pend = hsel && htrans[1] && hready && hwrite;
    if (hsel && htrans[1] && hready) begin
      st_next.addr = haddr;
    end

    // transmit handshake; toggle moves only when a reply really leaves
    if (st_reg.tx_valid && tx_ready) begin
      st_next.tx_valid = 1'b0;
      if (st_reg.tx_is_reply) begin
        st_next.toggle = !st_reg.toggle; // [RULE_17]
      end
    end

    case (st_reg.state)
      cng_pkg::CNG_INIT: begin
        if (st_reg.init_cnt == 8'h00) begin
          st_next.state = cng_pkg::CNG_BOOT; // [RULE_01]
          st_next.tx_valid = 1'b1; // [RULE_02]
          st_next.tx_is_reply = 1'b0;
          st_next.tx.id = own_id;
          st_next.tx.dlc = cng_pkg::DLC_REPLY;
          st_next.tx.d0 = cng_pkg::BOOT_DATA;
        end else begin
          st_next.init_cnt = st_reg.init_cnt - 8'h01;
        end
      end
      cng_pkg::CNG_BOOT: begin
        if (st_reg.tx_valid && tx_ready) begin
          st_next.state = cng_pkg::CNG_PREOP; // [RULE_01]
        end
      end
      cng_pkg::CNG_PREOP,
      cng_pkg::CNG_OPER,
      cng_pkg::CNG_STOP: begin
        if (sup_timeout) begin
          st_next.state = cng_pkg::CNG_PREOP; // [RULE_18]
        end
        // commands are taken silently: nothing is queued for transmit
        if (nmt_cmd) begin // [RULE_07]
          case (rx.d0) // [RULE_05]
            cng_pkg::CMD_START: st_next.state = cng_pkg::CNG_OPER;
            cng_pkg::CMD_STOP: st_next.state = cng_pkg::CNG_STOP;
            cng_pkg::CMD_PREOP: st_next.state = cng_pkg::CNG_PREOP;
            cng_pkg::CMD_RST_NODE: begin
              st_next.dev_rst = 1'b1; // [RULE_08]
              st_next.node_id = cng_pkg::NODE_ID_RST;
              st_next.hb_en = 1'b0;
              st_next.alarm = 1'b0;
              st_next.comm_rst = 1'b1;
            end
            cng_pkg::CMD_RST_COMM: st_next.comm_rst = 1'b1; // [RULE_08]
            default: ;
          endcase
        end
        if (guard_req) begin
          st_next.reply_pend = 1'b1; // [RULE_15]
        end
      end
      default: st_next.state = cng_pkg::CNG_INIT;
    endcase

    // load a pending guard reply into the idle transmit slot
    if (online && st_reg.reply_pend && !st_reg.tx_valid) begin
      st_next.tx_valid = 1'b1; // [RULE_15]
      st_next.tx_is_reply = 1'b1;
      st_next.tx.id = own_id;
      st_next.tx.dlc = cng_pkg::DLC_REPLY;
      st_next.tx.d0 = {st_reg.toggle, code}; // [RULE_16] [RULE_17]
      st_next.reply_pend = guard_req; // a request in this cycle is kept
    end

    // communication reset: objects back to defaults, through init again
    if (st_next.comm_rst) begin
      st_next.state = cng_pkg::CNG_INIT; // [RULE_08]
      st_next.init_cnt = INIT_LOAD;
      st_next.guard_interval = cng_pkg::GUARD_INTERVAL_RST;
      st_next.life_factor = cng_pkg::LIFE_FACTOR_RST;
      st_next.tx_valid = 1'b0;
      st_next.reply_pend = 1'b0;
      st_next.toggle = 1'b0;
    end

    // alarm: clear on re-enable, set wins over clear
    if (sup_en && !st_reg.sup_en_d) begin
      st_next.alarm = 1'b0; // [RULE_20]
    end
    if (sup_timeout) begin
      st_next.alarm = 1'b1; // [RULE_18]
    end

    // gating from the next state so it switches with the state
    st_next.permit.pdo = (st_next.state == cng_pkg::CNG_OPER); // [RULE_09]
    st_next.permit.sdo = (st_next.state == cng_pkg::CNG_OPER) || (st_next.state == cng_pkg::CNG_PREOP);
    st_next.permit.sync = st_next.permit.sdo;
    st_next.permit.emcy = st_next.permit.sdo;
    st_next.permit.nmt = st_next.permit.sdo || (st_next.state == cng_pkg::CNG_STOP);

    // setting registers read from the updated copy so a write just before is seen; status fields come from the current state
    st_next.rdata = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr)
        cng_pkg::ADDR_GUARD_INTERVAL: st_next.rdata[15:0] = st_next.guard_interval;
        cng_pkg::ADDR_LIFE_FACTOR: st_next.rdata[7:0] = st_next.life_factor;
        cng_pkg::ADDR_CTRL: begin
          st_next.rdata[cng_pkg::CTRL_NODE_LSB +: 7] = st_next.node_id;
          st_next.rdata[cng_pkg::CTRL_HB_BIT] = st_next.hb_en;
        end
        cng_pkg::ADDR_STATUS: begin
          st_next.rdata[cng_pkg::STAT_CODE_LSB +: 7] = code;
          st_next.rdata[cng_pkg::STAT_ALARM_BIT] = st_reg.alarm;
          st_next.rdata[cng_pkg::STAT_TOGGLE_BIT] = st_reg.toggle;
          st_next.rdata[cng_pkg::STAT_ACTIVE_BIT] = sup_active;
          st_next.rdata[cng_pkg::STAT_ENABLE_BIT] = sup_en;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= cng_pkg::CNG_INIT; // [RULE_01]
      st_reg.init_cnt <= INIT_LOAD;
      st_reg.guard_interval <= cng_pkg::GUARD_INTERVAL_RST;
      st_reg.life_factor <= cng_pkg::LIFE_FACTOR_RST;
      st_reg.node_id <= cng_pkg::NODE_ID_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign tx_valid = st_reg.tx_valid;
  assign tx = st_reg.tx;
  assign permit = st_reg.permit;
  assign guard_loss_alarm = st_reg.alarm;
  assign device_reset_req = st_reg.dev_rst;
  assign comm_reset_pulse = st_reg.comm_rst;
endmodule : cng_node

// [test/cng_node_sva.sv]
// assertion checker for the node state and guarding block
`timescale 1ns/1ps
module cng_node_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // frames
  input wire cng_pkg::cng_rx_t rx,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire cng_pkg::cng_tx_t tx,
  // state and indications
  input wire cng_pkg::cng_permit_t permit,
  input wire logic guard_loss_alarm,
  input wire logic device_reset_req,
  input wire logic comm_reset_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic last_reg;
  logic seen_reg;
  logic cmd;
  logic reply;
  assign cmd = rx.valid && !rx.rtr && rx.id == cng_pkg::ID_NMT && rx.dlc == cng_pkg::DLC_NMT;
  // boot frames go out while permit is all zero, so they never count as replies
  assign reply = tx_valid && tx_ready && permit != 5'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else if (comm_reset_pulse) begin
      seen_reg <= 1'b0;
    end else if (reply) begin
      last_reg <= tx.d0[7];
      seen_reg <= 1'b1;
    end
  end
  property p_gate;
    permit inside {5'h00, 5'h01, 5'h0f, 5'h1f};
  endproperty
  a_gate: assert property (p_gate) else $error("illegal permit pattern");
  property p_boot;
    tx_valid && permit == 5'h00 |-> tx.id[10:7] == 4'he && tx.dlc == cng_pkg::DLC_REPLY && tx.d0 == 8'h00;
  endproperty
  a_boot: assert property (p_boot) else $error("bad boot frame");
  property p_code;
    tx_valid && permit != 5'h00 |-> tx.d0[6:0] inside {7'h04, 7'h05, 7'h7f};
  endproperty
  a_code: assert property (p_code) else $error("bad state code in reply");
  property p_toggle;
    reply |-> tx.d0[7] == (seen_reg ? !last_reg : 1'b0);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not invert");
  property p_hold;
    tx_valid && !tx_ready && !rx.valid |=> tx_valid && $stable(tx);
  endproperty
  a_hold: assert property (p_hold) else $error("offered frame dropped or changed");
  property p_quiet;
    rx.valid && permit == 5'h00 |=> !device_reset_req && !comm_reset_pulse;
  endproperty
  a_quiet: assert property (p_quiet) else $error("traffic accepted in init");
  property p_silent;
    cmd && !tx_valid |=> !tx_valid;
  endproperty
  a_silent: assert property (p_silent) else $error("command was answered");
  property p_stop;
    cmd && rx.d0 == cng_pkg::CMD_STOP && rx.d1 == cng_pkg::DEST_ALL && permit != 5'h00 |=> permit == 5'h01;
  endproperty
  a_stop: assert property (p_stop) else $error("broadcast stop not obeyed");
  property p_dest;
    cmd && rx.d1[7] |=> $stable(permit);
  endproperty
  a_dest: assert property (p_dest) else $error("foreign destination obeyed");
  property p_reset;
    device_reset_req |-> comm_reset_pulse ##1 !device_reset_req ##[0:2] permit == 5'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("node reset sequence wrong");
  property p_alarm;
    $rose(guard_loss_alarm) |-> ##[0:1] permit == 5'h0f;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without preoperational");
  c_reply: cover property (reply ##[1:60] reply);
  c_alarm: cover property ($rose(guard_loss_alarm));
  c_reset: cover property (device_reset_req);
endmodule : cng_node_sva

bind cng_node cng_node_sva cng_node_sva_i (.clk(clk), .rst_n(rst_n), .rx(rx), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx(tx), .permit(permit), .guard_loss_alarm(guard_loss_alarm),
  .device_reset_req(device_reset_req), .comm_reset_pulse(comm_reset_pulse));

// [test/cng_master_model.sv]
// partner model: network master sending frames and taking the node's frames
`timescale 1ns/1ps
module cng_master_model (
  // clock
  input wire logic clk,
  // frames to the node
  output cng_pkg::cng_rx_t rx,
  // frames from the node
  input wire logic tx_valid,
  output logic tx_ready,
  input wire cng_pkg::cng_tx_t tx
);
  int lag = 0;
  int wait_cnt = 0;
  cng_pkg::cng_tx_t got[$];
  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end
  // a busy controller keeps the node's frame waiting for lag cycles
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx);
    tx_ready <= tx_valid && !tx_ready && wait_cnt >= lag;
    wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 1 : 0;
  end
  task automatic send(input logic rtr, input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] d0,
                      input logic [7:0] d1);
    rx <= {1'b1, rtr, id, dlc, d0, d1};
    @(posedge clk);
    // idle lines show a changed pattern so stale fields are never mistaken for a frame
    rx <= {1'b0, ~rx[31:0]};
    @(posedge clk);
  endtask : send
  // code then destination, fire and forget
  task automatic cmd(input logic [7:0] code, input logic [7:0] dest);
    send(1'b0, cng_pkg::ID_NMT, cng_pkg::DLC_NMT, code, dest);
  endtask : cmd
  // remote frame without data bytes
  task automatic guard(input logic [6:0] node);
    send(1'b1, cng_pkg::ID_GUARD_BASE + {4'h0, node}, cng_pkg::DLC_REQ, 8'h00, 8'h00);
  endtask : guard
endmodule : cng_master_model

// [test/tb_can_node_state_and_guarding.sv]
// self-checking bench of the node state and guarding block
`timescale 1ns/1ps
module tb_can_node_state_and_guarding;
  localparam int unsigned TICK = 8;
  // code, destination, permit, reply state code
  localparam logic [31:0] STEPS [4] = '{32'h0105_1f05, 32'h0200_0104, 32'h8005_0f7f, 32'h0185_0f7f};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic tx_valid;
  logic tx_ready;
  logic alarm;
  logic dev_req;
  logic comm_pulse;
  logic tgl = 1'b0;
  cng_pkg::cng_rx_t rx;
  cng_pkg::cng_tx_t tx;
  cng_pkg::cng_tx_t f;
  cng_pkg::cng_permit_t permit;
  int n_errors = 0;
  int tests_run = 0;
  int n_dev = 0;
  int n_comm = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_dev += (dev_req === 1'b1);
    n_comm += (comm_pulse === 1'b1);
  end
  cng_node #(.TICK_CYCLES(TICK)) cng_node_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx(rx), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx(tx), .permit(permit),
    .guard_loss_alarm(alarm), .device_reset_req(dev_req), .comm_reset_pulse(comm_pulse));
  cng_master_model cng_master_model_i (.clk(clk), .rx(rx), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx(tx));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // a wait that runs out ends the run at once
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask : bound
  task automatic ready_edge;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 40);
    bound(hreadyout);
  endtask : ready_edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    ready_edge();
    htrans <= 2'h0;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask : bus
  task automatic frame;
    int k;
    k = 0;
    while (cng_master_model_i.got.size() == 0 && k < 400) begin @(posedge clk); k++; end
    bound(cng_master_model_i.got.size() > 0);
    f = cng_master_model_i.got.pop_front();
  endtask : frame
  task automatic reply(input logic [6:0] code);
    cng_master_model_i.guard(7'h05);
    frame();
    chk("guard reply", {9'h000, 11'h705, cng_pkg::DLC_REPLY, tgl, code}, {9'h000, f});
    tgl = ~tgl;
  endtask : reply
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cng_master_model_i.cmd(cng_pkg::CMD_RST_NODE, 8'h00);
    bus(1'b0, cng_pkg::ADDR_GUARD_INTERVAL, 32'h0000_0000);
    chk("interval reset", 32'h0000_0000, rd);
    bus(1'b0, cng_pkg::ADDR_LIFE_FACTOR, 32'h0000_0000);
    chk("life reset", 32'h0000_0000, rd);
    bus(1'b1, 32'h0000_4048, 32'hffff_ffff);
    bus(1'b0, 32'h0000_4048, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    chk("okay response", 32'h0000_0000, hresp);
    frame();
    chk("boot frame", {9'h000, 11'h700, 4'h1, 8'h00}, {9'h000, f});
    chk("ignored reset", 32'h0000_0000, n_dev);
    repeat (2) @(posedge clk);
    chk("permit after boot", 32'h0000_000f, permit);
    $display("test boot done");
    bus(1'b1, cng_pkg::ADDR_CTRL, 32'h0000_0005);
    bus(1'b1, cng_pkg::ADDR_GUARD_INTERVAL, 32'h0000_0001);
    bus(1'b0, cng_pkg::ADDR_GUARD_INTERVAL, 32'h0000_0000);
    chk("shortest interval", 32'h0000_0001, rd);
    bus(1'b1, cng_pkg::ADDR_LIFE_FACTOR, 32'h0000_0006);
    repeat (100) @(posedge clk);
    chk("no timing before request", 32'h0000_0000, alarm);
    for (int i = 0; i < 4; i++) begin
      cng_master_model_i.cmd(STEPS[i][31:24], STEPS[i][23:16]);
      @(posedge clk);
      chk("permit", STEPS[i][15:8], permit);
      chk("no answer", 32'h0000_0000, cng_master_model_i.got.size());
      cng_master_model_i.lag = i;
      reply(STEPS[i][6:0]);
    end
    $display("test commands done");
    cng_master_model_i.cmd(cng_pkg::CMD_START, 8'h00);
    repeat (4) begin
      reply(7'h05);
      repeat (30) @(posedge clk);
    end
    // earliest timeout is 41 edges after the last request, plus one edge to reach the alarm
    repeat (4) @(posedge clk);
    chk("alarm before supervision time", 32'h0000_0000, alarm);
    for (int k = 0; k < 30 && alarm !== 1'b1; k++) @(posedge clk);
    bound(alarm);
    @(posedge clk);
    chk("permit after timeout", 32'h0000_000f, permit);
    $display("test timeout done");
    cng_master_model_i.cmd(cng_pkg::CMD_START, 8'h05);
    bus(1'b1, cng_pkg::ADDR_LIFE_FACTOR, 32'h0000_0000);
    reply(7'h05);
    repeat (80) @(posedge clk);
    chk("disabled supervision", 32'h0000_001f, permit);
    bus(1'b1, cng_pkg::ADDR_LIFE_FACTOR, 32'h0000_0006);
    repeat (2) @(posedge clk);
    chk("alarm cleared", 32'h0000_0000, alarm);
    bus(1'b0, cng_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status enabled", {20'h0_0000, 1'b1, 1'b0, tgl, 1'b0, 1'b0, cng_pkg::CODE_OPER}, rd);
    bus(1'b1, cng_pkg::ADDR_CTRL, 32'h0000_0105);
    bus(1'b0, cng_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status heartbeat", {20'h0_0000, 1'b0, 1'b0, tgl, 1'b0, 1'b0, cng_pkg::CODE_OPER}, rd);
    $display("test re-enable done");
    cng_master_model_i.cmd(cng_pkg::CMD_RST_COMM, 8'h05);
    frame();
    chk("boot after comm reset", {9'h000, 11'h705, 4'h1, 8'h00}, {9'h000, f});
    chk("comm pulses", 32'h0000_0001, n_comm);
    bus(1'b0, cng_pkg::ADDR_GUARD_INTERVAL, 32'h0000_0000);
    chk("interval after comm reset", 32'h0000_0000, rd);
    cng_master_model_i.cmd(cng_pkg::CMD_RST_NODE, 8'h00);
    frame();
    chk("boot after node reset", {9'h000, 11'h700, 4'h1, 8'h00}, {9'h000, f});
    chk("device resets", 32'h0000_0001, n_dev);
    $display("test resets done");
    give_verdict();
  end
endmodule : tb_can_node_state_and_guarding
